// ---- rtl/sensor_nvm_regs.svh ----
`ifndef SENSOR_NVM_REGS_SVH
`define SENSOR_NVM_REGS_SVH

// ----------------------------------------------------------------
// Bus address and command bytes
// ----------------------------------------------------------------
`define DEV_ADDR 7'h44
`define CMD_ENTER 8'hA0
`define CMD_LEAVE 8'h80

// ----------------------------------------------------------------
// Settings register addresses and fields
// ----------------------------------------------------------------
`define REG_HUM_RD 8'h06
`define REG_TEMP_RD 8'h11
`define REG_ID_HI 8'h1E
`define REG_ID_LO 8'h1F
`define REG_HUM_WR 8'h46
`define REG_TEMP_WR 8'h51
`define RES_MSB 11
`define RES_LSB 10
`define WORD_RESET 16'h0C00

// ----------------------------------------------------------------
// Timing, in ns, and derived clock counts
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 4
`define T_WINDOW_NS 10000000
`define T_ENTRY_NS 120000
`define T_READ_NS 120000
`define T_WRITE_NS 14000000
`define WINDOW_CYC (`T_WINDOW_NS / `CLK_PERIOD_NS)
`define ENTRY_CYC ((`T_ENTRY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_CYC ((`T_READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_CYC ((`T_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- rtl/sensor_nvm_pkg.sv ----
package sensor_nvm_pkg;
	// Operating mode after power-up
	typedef enum logic [1:0] {
		MODE_WINDOW = 2'b00,
		MODE_ENTRY = 2'b01,
		MODE_PROG = 2'b10,
		MODE_NORMAL = 2'b11
	} mode_t;
	typedef logic [15:0] word_t;
endpackage : sensor_nvm_pkg

// ---- rtl/nvm_port_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface nvm_port_if;
	logic wr_hum;
	logic wr_temp;
	logic rd_load;
	logic [7:0] sel;
	sensor_nvm_pkg::word_t wdata;
	sensor_nvm_pkg::word_t rdata;
	logic busy;
	logic [1:0] hum_res;
	logic [1:0] temp_res;
	modport store(input wr_hum, wr_temp, rd_load, sel, wdata,
		output rdata, busy, hum_res, temp_res);
	modport proto(output wr_hum, wr_temp, rd_load, sel, wdata,
		input rdata, busy, hum_res, temp_res);
endinterface : nvm_port_if
`default_nettype wire

// ---- rtl/pin_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [1:0] pin,
	output logic [1:0] pin_s
);
	logic [1:0] meta;
	logic [1:0] next_meta;
	logic [1:0] next_pin_s;

	// Two stages; the first feeds only the second
	always_comb begin
		next_meta = ce ? pin : meta;
		next_pin_s = ce ? meta : pin_s;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= 2'h3;
			pin_s <= 2'h3;
		end else begin
			meta <= next_meta;
			pin_s <= next_pin_s;
		end
	end
endmodule : pin_sync
`default_nettype wire

// ---- rtl/nvm_settings.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "sensor_nvm_regs.svh"
module nvm_settings #(
	parameter int unsigned READ_CYC = `READ_CYC,
	parameter int unsigned WRITE_CYC = `WRITE_CYC,
	parameter logic [31:0] ID_VALUE = 32'h5A5A_0001 // Arbitrary value
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	nvm_port_if.store np
);
	sensor_nvm_pkg::word_t hum_word, next_hum_word;
	sensor_nvm_pkg::word_t temp_word, next_temp_word;
	sensor_nvm_pkg::word_t pend, next_pend;
	sensor_nvm_pkg::word_t rdata, next_rdata;
	logic [21:0] tmr, next_tmr;
	logic busy, next_busy;
	logic is_wr, next_is_wr;
	logic to_hum, next_to_hum;
	logic [7:0] sel, next_sel;

	assign np.rdata = rdata;
	assign np.busy = busy;
	assign np.hum_res = hum_word[`RES_MSB:`RES_LSB];
	assign np.temp_res = temp_word[`RES_MSB:`RES_LSB];

	// Reads settle after a load delay; writes commit only after the
	// full program time; a reset mid-write reloads WORD_RESET, not the old setting
	always_comb begin
		next_hum_word = hum_word;
		next_temp_word = temp_word;
		next_pend = pend;
		next_rdata = rdata;
		next_tmr = tmr;
		next_busy = busy;
		next_is_wr = is_wr;
		next_to_hum = to_hum;
		next_sel = sel;
		if (busy) begin
			next_tmr = tmr + 22'h1;
			if (is_wr && tmr == 22'(WRITE_CYC - 1)) begin
				next_busy = 1'b0;
				if (to_hum) begin
					next_hum_word = pend;
				end else begin
					next_temp_word = pend;
				end
			end else if (!is_wr && tmr == 22'(READ_CYC - 1)) begin
				next_busy = 1'b0;
				case (sel)
					`REG_HUM_RD: next_rdata = hum_word;
					`REG_TEMP_RD: next_rdata = temp_word;
					`REG_ID_HI: next_rdata = ID_VALUE[31:16];
					`REG_ID_LO: next_rdata = ID_VALUE[15:0];
					default: next_rdata = 16'h0000;
				endcase
			end
		end else if (np.wr_hum || np.wr_temp) begin
			next_busy = 1'b1;
			next_is_wr = 1'b1;
			next_to_hum = np.wr_hum;
			next_pend = np.wdata;
			next_tmr = 22'h0;
		end else if (np.rd_load) begin
			next_busy = 1'b1;
			next_is_wr = 1'b0;
			next_sel = np.sel;
			next_tmr = 22'h0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hum_word <= `WORD_RESET;
			temp_word <= `WORD_RESET;
			pend <= 16'h0000;
			rdata <= 16'h0000;
			tmr <= 22'h0;
			busy <= 1'b0;
			is_wr <= 1'b0;
			to_hum <= 1'b0;
			sel <= 8'h00;
		end else if (ce) begin
			hum_word <= next_hum_word;
			temp_word <= next_temp_word;
			pend <= next_pend;
			rdata <= next_rdata;
			tmr <= next_tmr;
			busy <= next_busy;
			is_wr <= next_is_wr;
			to_hum <= next_to_hum;
			sel <= next_sel;
		end
	end
endmodule : nvm_settings
`default_nettype wire

// ---- rtl/sensor_nvm_program_access.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "sensor_nvm_regs.svh"
module sensor_nvm_program_access #(
	parameter int unsigned WINDOW_CYC = `WINDOW_CYC,
	parameter int unsigned ENTRY_CYC = `ENTRY_CYC,
	parameter int unsigned READ_CYC = `READ_CYC,
	parameter int unsigned WRITE_CYC = `WRITE_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_o,
	output logic sda_oe_n,
	input wire logic meas_valid,
	input wire logic [13:0] humidity_data,
	input wire logic [13:0] temperature_data,
	output logic prog_mode,
	output logic [1:0] humidity_res,
	output logic [1:0] temperature_res,
	output logic nvm_busy
);
	nvm_port_if np();
	logic [1:0] pin_s;
	logic scl_s, sda_s;
	logic scl_p, sda_p;
	logic active, first, rw, tx_on, mack, ack;
	logic [3:0] cnt;
	logic [7:0] rx, tx;
	logic next_scl_p, next_sda_p, next_oe_n;
	logic next_active, next_first, next_rw, next_tx_on, next_mack;
	logic [3:0] next_cnt;
	logic [7:0] next_rx, next_tx;
	logic byte_p, tx_p, stop_p;
	logic [7:0] tx_byte;
	sensor_nvm_pkg::mode_t mode, next_mode;
	logic [21:0] tmr, next_tmr;
	logic [1:0] idx, next_idx;
	logic [7:0] cmd, next_cmd, hi, next_hi;
	logic [2:0] rptr, next_rptr;
	logic next_ack, fetched, next_fetched;
	logic [13:0] hum_q, next_hum_q, temp_q, next_temp_q;
	logic wr_hum, wr_temp, rd_load, next_wr_hum, next_wr_temp;
	logic next_rd_load;
	logic [7:0] sel, next_sel;
	sensor_nvm_pkg::word_t wdata, next_wdata;

	// Commands whose answer is a settings word or an ID half
	function automatic logic is_read_reg(input logic [7:0] a);
		is_read_reg = (a == `REG_HUM_RD) || (a == `REG_TEMP_RD) ||
			(a == `REG_ID_HI) || (a == `REG_ID_LO);
	endfunction : is_read_reg

	// ----------------------------------------------------------------
	// Pin sampling and settings store
	// ----------------------------------------------------------------
	pin_sync u_sync (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.pin({scl, sda_in}),
		.pin_s(pin_s)
	);
	assign scl_s = pin_s[1];
	assign sda_s = pin_s[0];

	nvm_settings #(
		.READ_CYC(READ_CYC),
		.WRITE_CYC(WRITE_CYC)
	) u_nvm (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.np(np)
	);
	assign np.wr_hum = wr_hum;
	assign np.wr_temp = wr_temp;
	assign np.rd_load = rd_load;
	assign np.sel = sel;
	assign np.wdata = wdata;
	assign humidity_res = np.hum_res;
	assign temperature_res = np.temp_res;

	// ----------------------------------------------------------------
	// Bit level: start, stop, shifting, acknowledge, send
	// ----------------------------------------------------------------
	// Byte and pulse flags are combinational but sampled by the
	// protocol flops in the same cycle, so nothing is lost
	always_comb begin
		next_scl_p = scl_s;
		next_sda_p = sda_s;
		next_oe_n = sda_oe_n;
		next_active = active;
		next_first = first;
		next_rw = rw;
		next_tx_on = tx_on;
		next_mack = mack;
		next_cnt = cnt;
		next_rx = rx;
		next_tx = tx;
		byte_p = 1'b0;
		tx_p = 1'b0;
		stop_p = 1'b0;
		if (scl_s && scl_p && sda_p && !sda_s) begin
			next_active = 1'b1; // Start, also repeated start
			next_first = 1'b1;
			next_cnt = 4'h0;
			next_tx_on = 1'b0;
			next_oe_n = 1'b1;
		end else if (scl_s && scl_p && !sda_p && sda_s) begin
			next_active = 1'b0;
			next_tx_on = 1'b0;
			next_oe_n = 1'b1;
			stop_p = 1'b1;
		end else if (active && scl_s && !scl_p) begin
			if (cnt < 4'h8) begin
				next_rx = {rx[6:0], sda_s};
				next_cnt = cnt + 4'h1;
				byte_p = (cnt == 4'h7);
			end else begin
				next_cnt = 4'h9;
				next_mack = !sda_s; // Master acknowledge in a read
			end
		end else if (active && !scl_s && scl_p) begin
			if (cnt == 4'h8) begin
				next_oe_n = !(!tx_on && ack);
				if (first) begin
					next_rw = rx[0];
				end
				if (!tx_on && !ack) begin
					next_active = 1'b0;
				end
			end else if (cnt == 4'h9) begin
				next_cnt = 4'h0;
				next_first = 1'b0;
				if ((first && rw) || (tx_on && mack)) begin
					next_tx_on = 1'b1;
					next_oe_n = tx_byte[7];
					next_tx = {tx_byte[6:0], 1'b0};
					tx_p = 1'b1;
				end else begin
					next_tx_on = 1'b0;
					next_oe_n = 1'b1;
				end
			end else if (tx_on && cnt != 4'h0) begin
				next_oe_n = tx[7];
				next_tx = {tx[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_p <= 1'b1;
			sda_p <= 1'b1;
			sda_oe_n <= 1'b1;
			sda_o <= 1'b0;
			active <= 1'b0;
			first <= 1'b0;
			rw <= 1'b0;
			tx_on <= 1'b0;
			mack <= 1'b0;
			cnt <= 4'h0;
			rx <= 8'h00;
			tx <= 8'h00;
		end else if (ce) begin
			scl_p <= next_scl_p;
			sda_p <= next_sda_p;
			sda_oe_n <= next_oe_n;
			sda_o <= 1'b0; // Open drain: only ever pulls low
			active <= next_active;
			first <= next_first;
			rw <= next_rw;
			tx_on <= next_tx_on;
			mack <= next_mack;
			cnt <= next_cnt;
			rx <= next_rx;
			tx <= next_tx;
		end
	end

	// ----------------------------------------------------------------
	// Byte to send next
	// ----------------------------------------------------------------
	// Past the defined bytes the device sends zeros up to the eighth byte; rptr then wraps to 0
	always_comb begin
		tx_byte = 8'h00;
		if (mode == sensor_nvm_pkg::MODE_PROG) begin
			case (rptr)
				3'h0: tx_byte = np.rdata[15:8];
				3'h1: tx_byte = np.rdata[7:0];
				default: tx_byte = 8'h00;
			endcase
		end else begin
			case (rptr)
				3'h0: tx_byte = {1'b0, fetched, hum_q[13:8]};
				3'h1: tx_byte = hum_q[7:0];
				3'h2: tx_byte = temp_q[13:6];
				3'h3: tx_byte = {temp_q[5:0], 2'h0};
				default: tx_byte = 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Mode, command decode and measurement output
	// ----------------------------------------------------------------
	// Addresses are refused while entry or the store is busy, so an
	// impatient master sees a NACK instead of corrupting a setting
	always_comb begin
		next_mode = mode;
		next_tmr = tmr;
		next_idx = idx;
		next_cmd = cmd;
		next_hi = hi;
		next_rptr = rptr;
		next_ack = ack;
		next_fetched = fetched;
		next_hum_q = hum_q;
		next_temp_q = temp_q;
		next_wr_hum = 1'b0;
		next_wr_temp = 1'b0;
		next_rd_load = 1'b0;
		next_sel = sel;
		next_wdata = wdata;
		case (mode)
			sensor_nvm_pkg::MODE_WINDOW: begin
				next_tmr = tmr + 22'h1;
				if (tmr == 22'(WINDOW_CYC - 1)) begin
					next_mode = sensor_nvm_pkg::MODE_NORMAL;
				end
			end
			sensor_nvm_pkg::MODE_ENTRY: begin
				next_tmr = tmr + 22'h1;
				if (tmr == 22'(ENTRY_CYC - 1)) begin
					next_mode = sensor_nvm_pkg::MODE_PROG;
				end
			end
			default: next_tmr = tmr;
		endcase
		if (meas_valid) begin
			next_hum_q = humidity_data;
			next_temp_q = temperature_data;
			next_fetched = 1'b0;
		end
		if (tx_p) begin
			next_rptr = rptr + 3'h1;
			if (mode == sensor_nvm_pkg::MODE_NORMAL && rptr == 3'h0) begin
				next_fetched = 1'b1; // Fetch wins over a new sample
			end
		end
		if (stop_p) begin
			next_ack = 1'b0;
		end
		if (byte_p && first) begin
			next_ack = (next_rx[7:1] == `DEV_ADDR) && !np.busy &&
				mode != sensor_nvm_pkg::MODE_ENTRY;
			next_idx = 2'h0;
			next_rptr = 3'h0;
		end else if (byte_p && !rw) begin
			next_idx = idx + 2'h1;
			next_ack = (idx != 2'h3);
			case (idx)
				2'h0: next_cmd = next_rx;
				2'h1: next_hi = next_rx;
				2'h2: begin
					if (cmd == `CMD_ENTER && hi == 8'h00 && next_rx == 8'h00 &&
						mode == sensor_nvm_pkg::MODE_WINDOW) begin
						next_mode = sensor_nvm_pkg::MODE_ENTRY;
						next_tmr = 22'h0;
					end else if (mode == sensor_nvm_pkg::MODE_PROG) begin
						if (cmd == `CMD_LEAVE && hi == 8'h00 && next_rx == 8'h00) begin
							next_mode = sensor_nvm_pkg::MODE_NORMAL;
						end else if (is_read_reg(cmd)) begin
							next_rd_load = 1'b1;
							next_sel = cmd;
						end else if (cmd == `REG_HUM_WR) begin
							next_wr_hum = 1'b1;
							next_wdata = {hi, next_rx};
						end else if (cmd == `REG_TEMP_WR) begin
							next_wr_temp = 1'b1;
							next_wdata = {hi, next_rx};
						end
					end
				end
				default: next_idx = idx;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode <= sensor_nvm_pkg::MODE_WINDOW;
			tmr <= 22'h0;
			idx <= 2'h0;
			cmd <= 8'h00;
			hi <= 8'h00;
			rptr <= 3'h0;
			ack <= 1'b0;
			fetched <= 1'b0;
			hum_q <= 14'h0000;
			temp_q <= 14'h0000;
			wr_hum <= 1'b0;
			wr_temp <= 1'b0;
			rd_load <= 1'b0;
			sel <= 8'h00;
			wdata <= 16'h0000;
			prog_mode <= 1'b0;
			nvm_busy <= 1'b0;
		end else if (ce) begin
			mode <= next_mode;
			tmr <= next_tmr;
			idx <= next_idx;
			cmd <= next_cmd;
			hi <= next_hi;
			rptr <= next_rptr;
			ack <= next_ack;
			fetched <= next_fetched;
			hum_q <= next_hum_q;
			temp_q <= next_temp_q;
			wr_hum <= next_wr_hum;
			wr_temp <= next_wr_temp;
			rd_load <= next_rd_load;
			sel <= next_sel;
			wdata <= next_wdata;
			prog_mode <= (next_mode == sensor_nvm_pkg::MODE_PROG);
			nvm_busy <= np.busy;
		end
	end
endmodule : sensor_nvm_program_access
`default_nettype wire

// ---- dv/bus_master_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Link master: 32 ns bit period, scl stands high between frames
// ----------------------------------------------------------------
module bus_master_model (
	input wire logic sda,
	output logic scl,
	output logic sda_drv,
	output logic [7:0] res_val,
	output logic res_valid
);
	// Both lines released at time zero, as the pull-ups leave them
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
		res_val = 8'h00;
		res_valid = 1'b0;
	end
	// Short strobe so the bench monitor sees every result
	task automatic post(input logic [7:0] v);
		res_val = v;
		res_valid = 1'b1;
		#2 res_valid = 1'b0;
	endtask : post
	// Data moves only while scl is low; sampled late in the high phase
	task automatic clk_bit(input logic b, output logic s);
		sda_drv = b;
		#8 scl = 1'b1;
		#15 s = sda;
		#1 scl = 1'b0;
		#8;
	endtask : clk_bit
	task automatic start();
		sda_drv = 1'b1;
		#8 scl = 1'b1;
		#8 sda_drv = 1'b0;
		#8 scl = 1'b0;
		#8;
	endtask : start
	task automatic stop();
		sda_drv = 1'b0;
		#8 scl = 1'b1;
		#8 sda_drv = 1'b1;
		#16;
	endtask : stop
	// Byte out, msb first, then the acknowledge bit is posted
	task automatic put(input logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
		clk_bit(1'b1, s);
		post({7'h00, s});
	endtask : put
	// Byte in; the last one is refused to end the device's sending
	task automatic get(input logic last);
		logic [7:0] v;
		logic s;
		for (int i = 0; i < 8; i++) begin
			clk_bit(1'b1, s);
			v = {v[6:0], s};
		end
		clk_bit(last, s);
		post(v);
	endtask : get
	// Register byte, then the word msb first
	task automatic cmd(input logic [6:0] a, input logic [7:0] r,
		input logic [15:0] w);
		start();
		put({a, 1'b0}); // Write direction
		put(r);
		put(w[15:8]);
		put(w[7:0]);
		stop();
	endtask : cmd
	task automatic fetch(input logic [6:0] a, input int n);
		start();
		put({a, 1'b1}); // Read direction
		for (int i = 0; i < n; i++) get(i == n - 1);
		stop();
	endtask : fetch
endmodule : bus_master_model
`default_nettype wire

// ---- dv/sensor_nvm_program_access_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module nvm_access_sva #(
	parameter int unsigned WINDOW_CYC = 2500000,
	parameter int unsigned ENTRY_CYC = 30000,
	parameter int unsigned READ_CYC = 30000,
	parameter int unsigned WRITE_CYC = 3500000
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic prog_mode,
	input wire logic [1:0] humidity_res,
	input wire logic [1:0] temperature_res,
	input wire logic nvm_busy
);
	logic [31:0] cyc, next_cyc, busy_len, next_busy_len;
	logic [31:0] last_len, next_last_len;
	logic seen, next_seen;
	// Age since reset saturates so a long run cannot wrap back
	always_comb begin
		next_cyc = (cyc == 32'hFFFFFFFF) ? cyc : cyc + 32'h1;
		next_busy_len = nvm_busy ? busy_len + 32'h1 : 32'h0;
		next_last_len = (!nvm_busy && busy_len != 0) ? busy_len : last_len;
		next_seen = seen | prog_mode;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cyc <= 32'h0;
			busy_len <= 32'h0;
			last_len <= 32'h0;
			seen <= 1'b0;
		end else begin
			cyc <= next_cyc;
			busy_len <= next_busy_len;
			last_len <= next_last_len;
			seen <= next_seen;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// A stored word lands only as a full write period ends
	sequence store_done;
		##[0:3] (!nvm_busy && last_len + 1 >= WRITE_CYC);
	endsequence
	rst_state_a: assert property (
		$fell(rst) |-> !prog_mode && !nvm_busy && humidity_res == 2'b11
			&& temperature_res == 2'b11)
		else $error("state after reset wrong");
	entry_delay_a: assert property (
		$rose(prog_mode) |-> cyc > ENTRY_CYC)
		else $error("programming mode too early");
	entry_window_a: assert property (
		$rose(prog_mode) |-> cyc <= WINDOW_CYC + ENTRY_CYC + 8)
		else $error("programming mode after window");
	no_reentry_a: assert property (
		seen && !prog_mode |=> !prog_mode)
		else $error("programming mode re-entered");
	busy_mode_a: assert property (
		$rose(nvm_busy) |-> prog_mode)
		else $error("store busy outside programming mode");
	busy_len_a: assert property (
		$fell(nvm_busy) |-> busy_len + 1 >= READ_CYC)
		else $error("store busy too short");
	busy_hold_a: assert property (
		nvm_busy && prog_mode |=> prog_mode)
		else $error("left programming mode while busy");
	hum_change_a: assert property (
		$changed(humidity_res) |-> prog_mode ##0 store_done)
		else $error("humidity resolution changed without write");
	temp_change_a: assert property (
		$changed(temperature_res) |-> prog_mode ##0 store_done)
		else $error("temperature resolution changed without write");
	indep_a: assert property (
		!($changed(humidity_res) && $changed(temperature_res)))
		else $error("resolutions changed together");
endmodule : nvm_access_sva
bind sensor_nvm_program_access nvm_access_sva #(
	.WINDOW_CYC(WINDOW_CYC),
	.ENTRY_CYC(ENTRY_CYC),
	.READ_CYC(READ_CYC),
	.WRITE_CYC(WRITE_CYC)
) u_sva (
	.clk(clk),
	.rst(rst),
	.prog_mode(prog_mode),
	.humidity_res(humidity_res),
	.temperature_res(temperature_res),
	.nvm_busy(nvm_busy)
);
`default_nettype wire

// ---- dv/sensor_nvm_program_access_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module sensor_nvm_program_access_tb_top;
	localparam int unsigned WIN = 2000;
	localparam int unsigned ENT = 20;
	localparam logic [31:0] ID_EXPECT = 32'h5A5A0001; // Arbitrary value
	localparam logic [6:0] ADDR = 7'h44;
	logic clk, rst, ce, meas_valid, scl, sda_drv, sda_o, sda_oe_n;
	logic prog_mode, nvm_busy, res_valid;
	logic [13:0] hum, temp;
	logic [1:0] hres, tres;
	logic [7:0] res_val;
	logic [7:0] exp_q[$];
	int fail_count = 0;
	int total_checks = 0;
	int cycles = 0;
	// Open-drain wire with pull-up: low if either party pulls
	wire logic sda = sda_drv & (sda_oe_n | sda_o);
	sensor_nvm_program_access #(.WINDOW_CYC(WIN), .ENTRY_CYC(ENT),
		.READ_CYC(20), .WRITE_CYC(40)) dut (.clk(clk), .rst(rst),
		.ce(ce), .scl(scl), .sda_in(sda), .sda_o(sda_o),
		.sda_oe_n(sda_oe_n), .meas_valid(meas_valid),
		.humidity_data(hum), .temperature_data(temp),
		.prog_mode(prog_mode), .humidity_res(hres),
		.temperature_res(tres), .nvm_busy(nvm_busy));
	bus_master_model m (.sda(sda), .scl(scl), .sda_drv(sda_drv),
		.res_val(res_val), .res_valid(res_valid));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic summarize();
		// A result the link never delivered counts as a mismatch
		if (exp_q.size() != 0) fail_count++;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : summarize
	// Hang guard sized well above the expected run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			fail_count++;
			summarize();
		end
	end
	task automatic cmp_res(input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected bus byte: expected %h seen %h", e, g);
		end
	endtask : cmp_res
	task automatic cmp_out(input string n, input logic [1:0] e,
		input logic [1:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask : cmp_out
	// Every acknowledge and fetched byte is matched against the notes
	always @(posedge res_valid) begin
		if (exp_q.size() == 0) exp_q.push_back(8'hEE);
		cmp_res(exp_q.pop_front(), res_val);
	end
	task automatic reset_dut();
		@(posedge clk);
		#1 rst = 1'b1;
		repeat (5) @(posedge clk);
		#1 rst = 1'b0;
	endtask : reset_dut
	task automatic send(input logic [6:0] a, input logic [7:0] r,
		input logic [15:0] w, input logic [7:0] ak);
		repeat (4) exp_q.push_back(ak);
		m.cmd(a, r, w);
	endtask : send
	task automatic wait_idle();
		repeat (4) @(posedge clk);
		for (int n = 0; n < 200 && nvm_busy !== 1'b0; n++) @(posedge clk);
		#1;
	endtask : wait_idle
	task automatic rd_word(input logic [7:0] r, input logic [15:0] w);
		send(ADDR, r, 16'h0000, 8'h00);
		wait_idle();
		exp_q.push_back(8'h00);
		exp_q.push_back(w[15:8]);
		exp_q.push_back(w[7:0]);
		m.fetch(ADDR, 2);
	endtask : rd_word
	initial begin
		logic [15:0] hw;
		logic [15:0] tw;
		logic [1:0] c;
		hw = 16'h0C00;
		tw = 16'h0C00;
		rst = 1'b1;
		ce = 1'b1;
		meas_valid = 1'b0;
		hum = 14'h0000;
		temp = 14'h0000;
		void'($urandom(19));
		repeat (5) @(posedge clk);
		#1 rst = 1'b0;
		cmp_out("humidity_res", 2'b11, hres);
		cmp_out("temperature_res", 2'b11, tres);
		send(7'h45, 8'hA0, 16'h0000, 8'h01);
		$display("test reset and foreign address done");
		send(ADDR, 8'hA0, 16'h0000, 8'h00);
		repeat (ENT) @(posedge clk);
		cmp_out("prog_mode", 2'b01, {1'b0, prog_mode});
		rd_word(8'h06, hw);
		rd_word(8'h11, tw);
		rd_word(8'h1E, ID_EXPECT[31:16]);
		rd_word(8'h1F, ID_EXPECT[15:0]);
		$display("test register reads done");
		// Every code, read-modify-write so other bits stay as read
		for (int i = 0; i < 4; i++) begin
			rd_word(8'h06, hw);
			c = hw[11:10];
			hw[11:10] = 2'(i);
			send(ADDR, 8'h46, hw, 8'h00);
			// Enable low mid-write: store must hold busy and the old code
			@(posedge clk);
			#1 ce = 1'b0;
			repeat (40) @(posedge clk);
			#1 cmp_out("nvm_busy", 2'b01, {1'b0, nvm_busy});
			cmp_out("humidity_res", c, hres);
			ce = 1'b1;
			wait_idle();
			cmp_out("humidity_res", 2'(i), hres);
			cmp_out("temperature_res", 2'b11, tres);
		end
		c = 2'($urandom);
		rd_word(8'h11, tw);
		tw[11:10] = c;
		send(ADDR, 8'h51, tw, 8'h00);
		wait_idle();
		cmp_out("temperature_res", c, tres);
		cmp_out("humidity_res", 2'b11, hres);
		rd_word(8'h06, hw);
		rd_word(8'h11, tw);
		$display("test resolution writes done");
		send(ADDR, 8'h80, 16'h0000, 8'h00);
		send(ADDR, 8'h46, 16'h0000, 8'h00);
		repeat (60) @(posedge clk);
		cmp_out("prog_mode", 2'b00, {1'b0, prog_mode});
		cmp_out("humidity_res", 2'b11, hres);
		#1 hum = 14'($urandom);
		temp = 14'($urandom);
		meas_valid = 1'b1;
		@(posedge clk);
		#1 meas_valid = 1'b0;
		exp_q.push_back(8'h00);
		exp_q.push_back({2'b00, hum[13:8]});
		exp_q.push_back(hum[7:0]);
		exp_q.push_back(temp[13:6]);
		exp_q.push_back({temp[5:0], 2'b00});
		m.fetch(ADDR, 4);
		exp_q.push_back(8'h00);
		exp_q.push_back({2'b01, hum[13:8]});
		m.fetch(ADDR, 1);
		$display("test leave and measurement fetch done");
		reset_dut();
		repeat (WIN) @(posedge clk);
		send(ADDR, 8'hA0, 16'h0000, 8'h00);
		repeat (ENT + 10) @(posedge clk);
		cmp_out("prog_mode", 2'b00, {1'b0, prog_mode});
		$display("test late entry done");
		summarize();
	end
endmodule : sensor_nvm_program_access_tb_top
`default_nettype wire
